// [include/ccc_pkg.sv]
// shared constants and carriers of the charge cycle controller
package ccc_pkg;

    // apb register byte offsets
    localparam logic [7:0] CCC_CTRL_OFS = 8'h00;
    localparam logic [7:0] CCC_STATUS_OFS = 8'h04;
    localparam logic [7:0] CCC_TIMER_OFS = 8'h08;
    localparam logic [7:0] CCC_RETRY_OFS = 8'h0c;

    // control register fields and reset value
    localparam int CCC_CTRL_INHIBIT_BIT = 0;
    localparam int CCC_CTRL_SUPPL_BIT = 1;
    localparam logic [1:0] CCC_CTRL_RESET = 2'h0;

    // clock and timing
    localparam int CCC_CLK_PERIOD_NS = 4;
    localparam int CCC_TICK_NS = 1000000;
    localparam int CCC_TICK_CYCLES_DEF = CCC_TICK_NS / CCC_CLK_PERIOD_NS;
    localparam int CCC_SAFETY_SHORT_H = 2;
    localparam int CCC_SAFETY_LONG_H = 10;
    localparam int CCC_TICKS_PER_H = 3600 * 1000;
    localparam int CCC_SAFETY_SHORT_DEF = CCC_SAFETY_SHORT_H * CCC_TICKS_PER_H;
    localparam int CCC_SAFETY_LONG_DEF = CCC_SAFETY_LONG_H * CCC_TICKS_PER_H;
    localparam int CCC_BLINK_MS = 500;
    localparam logic [9:0] CCC_BLINK_TICKS = 10'(CCC_BLINK_MS * 1000000 / CCC_TICK_NS);
    localparam logic [2:0] CCC_BOOST_RETRIES = 3'h7;

    // charge cycle states
    typedef enum logic [2:0] {
        CCC_IDLE,
        CCC_CHARGING,
        CCC_DONE,
        CCC_TIMER_FAULT
    } ccc_state_t;

    // charge current selection
    typedef enum logic [1:0] {
        CCC_I_FAST,
        CCC_I_COOL_20PCT,
        CCC_I_PRE_5PCT,
        CCC_I_SHORT
    } ccc_isel_t;

    // synchronous comparator flags from the analog side
    typedef struct packed {
        logic conv_running;
        logic fast_charge_current_below_term;
        logic vbat_above_recharge;
        logic power_regulation_state;
        logic thermal_regulation;
        logic vin_regulation;
        logic iin_regulation;
        logic ts_in_charge_zone;
        logic ts_cool;
        logic ts_warm;
        logic ts_boost_window;
        logic vbat_below_low;
        logic vbat_below_short;
        logic input_overvoltage;
        logic system_overvoltage;
        logic battery_overvoltage;
        logic bus_short;
        logic die_above_shutdown;
        logic die_below_restore;
        logic vbat_below_depletion;
        logic battery_overcurrent;
        logic input_plugin;
        logic boost_request;
        logic supplement_demand;
    } ccc_sense_t;

    // drive signals to the power stage
    typedef struct packed {
        logic high_side_switch;
        logic switching_enable;
        logic system_discharge_sink;
        logic battery_switch;
        logic charge_enable;
        ccc_isel_t current_sel;
        logic voltage_reduced;
        logic reverse_supply_output;
    } ccc_drive_t;

endpackage

// [hw/ccc_charge_cycle_controller.sv]
`timescale 1ns/1ps
// Summary of operation
// - start only with converter, enable, thermistor, timer ok
// - terminate on low current, high voltage, no regulation
// - restart after termination below recharge threshold
// - charge enable toggle after done restarts charging
// - status low charging, high done/off, blink fault
// - battery switch off when done, supplement re-enables
// - thermistor outside charge zone suspends charging
// - cool zone selects one fifth current
// - warm zone selects reduced voltage target
// - boost suspended outside boost thermistor window
// - safety timer two or ten hours by battery
// - timer half rate during input or thermal regulation and in the cool zone
// - timer frozen on fault, cleared on restart
// - input overvoltage halts high side switch
// - system overvoltage stops switching, enables sink
// - bus short retries seven times then disables
// - thermal regulation disables termination, half rate
// - boost overtemperature opens switch, hysteresis restores
// - battery overvoltage disables charging immediately
// - depletion latches switch off until plug-in
// - short or precharge current below thresholds
// - overcurrent latches switch off until plug-in
module ccc_charge_cycle_controller #(
    parameter int TICK_CYCLES = ccc_pkg::CCC_TICK_CYCLES_DEF,
    parameter int SAFETY_SHORT_TICKS = ccc_pkg::CCC_SAFETY_SHORT_DEF,
    parameter int SAFETY_LONG_TICKS = ccc_pkg::CCC_SAFETY_LONG_DEF
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // pins and analog flags
    input wire logic charge_enable_n,
    input wire ccc_pkg::ccc_sense_t sense,
    // power stage and status pin
    output ccc_pkg::ccc_drive_t drive,
    output logic status_out
);
    import ccc_pkg::*;

    ccc_state_t state_reg; // charge cycle state
    ccc_state_t state_next;
    logic [1:0] ctrl_reg; // software control bits
    logic [31:0] tick_cnt_reg; // prescaler toward one timer tick
    logic tick_reg; // one-cycle tick pulse
    logic half_phase_reg; // alternates to halve the timer rate
    logic [31:0] safety_cnt_reg; // elapsed safety timer ticks
    logic [9:0] blink_cnt_reg; // blink half period counter
    logic blink_reg; // blink phase
    logic latch_off_reg; // depletion or overcurrent latch
    logic therm_shut_reg; // boost overtemperature shutdown
    logic [2:0] retry_cnt_reg; // bus short retries spent
    logic otg_dead_reg; // retries exhausted
    logic short_seen_reg; // previous bus short, for edge detect
    logic start_ok; // start conditions of a cycle
    logic charge_fault; // conditions that pause charging
    logic terminate_ok; // termination conditions
    logic half_rate; // vin, iin or thermal regulation, or cool zone active
    logic timer_expired;
    logic restart; // a fresh cycle begins this cycle
    logic short_rise;
    logic boost_ok;
    logic apb_setup;
    logic apb_write;

    assign apb_setup = psel && !penable;
    assign apb_write = psel && penable && pready && pwrite;

    // start needs converter, enable low, thermistor in zone, no timer fault
    assign start_ok = sense.conv_running && !charge_enable_n && !ctrl_reg[CCC_CTRL_INHIBIT_BIT]
        && sense.ts_in_charge_zone && !timer_expired;
    // pauses charging and freezes the timer
    assign charge_fault = !sense.ts_in_charge_zone || sense.battery_overvoltage
        || sense.input_overvoltage || sense.system_overvoltage;
    // regulation loops keep the cycle alive even when current looks low
    assign terminate_ok = sense.fast_charge_current_below_term && sense.vbat_above_recharge
        && !sense.power_regulation_state && !sense.thermal_regulation;
    assign half_rate = sense.vin_regulation || sense.iin_regulation
        || sense.ts_cool || sense.thermal_regulation;
    assign timer_expired = sense.vbat_below_low ? (safety_cnt_reg >= 32'(SAFETY_SHORT_TICKS))
        : (safety_cnt_reg >= 32'(SAFETY_LONG_TICKS));
    assign restart = (state_reg != CCC_CHARGING) && (state_next == CCC_CHARGING);
    assign short_rise = sense.bus_short && !short_seen_reg;

    // next state of the charge cycle
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            CCC_IDLE: begin
                if (start_ok) begin
                    state_next = CCC_CHARGING;
                end
            end
            CCC_CHARGING: begin
                if (charge_enable_n || ctrl_reg[CCC_CTRL_INHIBIT_BIT]) begin
                    state_next = CCC_IDLE;
                end else if (timer_expired) begin
                    state_next = CCC_TIMER_FAULT;
                end else if (terminate_ok && !charge_fault) begin
                    state_next = CCC_DONE;
                end
            end
            CCC_DONE: begin
                if (charge_enable_n) begin
                    state_next = CCC_IDLE;
                end else if (!sense.vbat_above_recharge && start_ok) begin
                    state_next = CCC_CHARGING;
                end
            end
            default: begin
                // timer fault holds until the cycle is stopped
                if (charge_enable_n) begin
                    state_next = CCC_IDLE;
                end
            end
        endcase
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= CCC_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // timer tick prescaler, long enough that the counter stays narrow
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt_reg <= 32'h0;
            tick_reg <= 1'b0;
        end else if (tick_cnt_reg >= 32'(TICK_CYCLES - 1)) begin
            tick_cnt_reg <= 32'h0;
            tick_reg <= 1'b1;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 32'h1;
            tick_reg <= 1'b0;
        end
    end

    // safety timer: cleared on restart, frozen on fault, halved in regulation
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            safety_cnt_reg <= 32'h0;
            half_phase_reg <= 1'b0;
        end else if (restart || state_reg == CCC_IDLE) begin
            // stopping sheds the count, so restart is possible
            safety_cnt_reg <= 32'h0;
            half_phase_reg <= 1'b0;
        end else if (state_reg == CCC_CHARGING && !charge_fault && tick_reg) begin
            half_phase_reg <= !half_phase_reg;
            if (!half_rate || half_phase_reg) begin
                safety_cnt_reg <= safety_cnt_reg + 32'h1;
            end
        end
    end

    // blink generator for the fault indication
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            blink_cnt_reg <= 10'h0;
            blink_reg <= 1'b0;
        end else if (tick_reg) begin
            if (blink_cnt_reg >= CCC_BLINK_TICKS - 10'h1) begin
                blink_cnt_reg <= 10'h0;
                blink_reg <= !blink_reg;
            end else begin
                blink_cnt_reg <= blink_cnt_reg + 10'h1;
            end
        end
    end

    // battery switch latch; a new event in the plug-in cycle still wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            latch_off_reg <= 1'b0;
        end else if (sense.vbat_below_depletion || sense.battery_overcurrent) begin
            latch_off_reg <= 1'b1;
        end else if (sense.input_plugin) begin
            latch_off_reg <= 1'b0;
        end
    end

    // boost thermal shutdown with hysteresis
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            therm_shut_reg <= 1'b0;
        end else if (sense.boost_request && sense.die_above_shutdown) begin
            therm_shut_reg <= 1'b1;
        end else if (sense.die_below_restore) begin
            therm_shut_reg <= 1'b0;
        end
    end

    // bus short retry counting; dropping the request rearms it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            short_seen_reg <= 1'b0;
            retry_cnt_reg <= 3'h0;
            otg_dead_reg <= 1'b0;
        end else begin
            short_seen_reg <= sense.bus_short;
            if (!sense.boost_request) begin
                retry_cnt_reg <= 3'h0;
                otg_dead_reg <= 1'b0;
            end else if (short_rise) begin
                if (retry_cnt_reg == CCC_BOOST_RETRIES) begin
                    otg_dead_reg <= 1'b1;
                end else begin
                    retry_cnt_reg <= retry_cnt_reg + 3'h1;
                end
            end
        end
    end

    // boost runs only inside the thermistor window and off a short
    assign boost_ok = sense.boost_request && sense.ts_boost_window
        && !therm_shut_reg && !otg_dead_reg && !sense.bus_short;

    // power stage drive, all from flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drive <= '0;
        end else begin
            drive.high_side_switch <= !sense.input_overvoltage && !sense.system_overvoltage;
            drive.switching_enable <= !sense.system_overvoltage;
            drive.system_discharge_sink <= sense.system_overvoltage;
            drive.battery_switch <= !latch_off_reg && !therm_shut_reg
                && (state_next != CCC_DONE || sense.supplement_demand
                || ctrl_reg[CCC_CTRL_SUPPL_BIT]);
            drive.charge_enable <= (state_next == CCC_CHARGING) && !charge_fault;
            if (sense.vbat_below_short) begin
                drive.current_sel <= CCC_I_SHORT;
            end else if (sense.vbat_below_low) begin
                drive.current_sel <= CCC_I_PRE_5PCT;
            end else if (sense.ts_cool) begin
                drive.current_sel <= CCC_I_COOL_20PCT;
            end else begin
                drive.current_sel <= CCC_I_FAST;
            end
            drive.voltage_reduced <= sense.ts_warm;
            drive.reverse_supply_output <= boost_ok;
        end
    end

    // status pin: low charging, blink on fault, high otherwise
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_out <= 1'b1;
        end else if (state_next == CCC_CHARGING) begin
            status_out <= 1'b0;
        end else if (state_next == CCC_TIMER_FAULT) begin
            status_out <= blink_reg;
        end else begin
            status_out <= 1'b1;
        end
    end

    // control register write, taken on the access edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= CCC_CTRL_RESET;
        end else if (apb_write && paddr == CCC_CTRL_OFS) begin
            ctrl_reg <= pwdata[1:0];
        end
    end

    // read data and ready prepared at setup, so every access has one wait-free cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= apb_setup;
            pslverr <= 1'b0;
            prdata <= 32'h0;
            if (apb_setup) begin
                if (paddr == CCC_CTRL_OFS) begin
                    prdata <= {30'h0, ctrl_reg};
                end else if (paddr == CCC_STATUS_OFS) begin
                    prdata <= {22'h0, otg_dead_reg, therm_shut_reg, latch_off_reg,
                        status_out, drive.battery_switch, drive.charge_enable, 1'b0, state_reg};
                end else if (paddr == CCC_TIMER_OFS) begin
                    prdata <= safety_cnt_reg;
                end else if (paddr == CCC_RETRY_OFS) begin
                    prdata <= {29'h0, retry_cnt_reg};
                end else begin
                    pslverr <= 1'b1; // unmapped address
                end
            end
        end
    end

    // sequences shared by the checks
    sequence s_terminate;
        state_reg == CCC_CHARGING && !charge_enable_n && !ctrl_reg[CCC_CTRL_INHIBIT_BIT]
            && !timer_expired && terminate_ok && !charge_fault;
    endsequence

    sequence s_restart_low;
        state_reg == CCC_DONE && !charge_enable_n && !sense.vbat_above_recharge && start_ok;
    endsequence

    a_start_needs_ok: assert property (@(posedge pclk) disable iff (!presetn)
        state_reg == CCC_IDLE && state_next == CCC_CHARGING |-> start_ok)
        else $error("cycle started without start conditions");

    a_terminate_done: assert property (@(posedge pclk) disable iff (!presetn)
        s_terminate |=> state_reg == CCC_DONE ##0 status_out)
        else $error("termination did not reach done");

    a_recharge_start: assert property (@(posedge pclk) disable iff (!presetn)
        s_restart_low |=> state_reg == CCC_CHARGING && safety_cnt_reg == 32'h0)
        else $error("recharge did not start a cleared cycle");

    a_status_charging: assert property (@(posedge pclk) disable iff (!presetn)
        state_reg == CCC_CHARGING |-> !status_out)
        else $error("status not low while charging");

    a_done_switch_off: assert property (@(posedge pclk) disable iff (!presetn)
        state_reg == CCC_DONE && !sense.supplement_demand && !ctrl_reg[CCC_CTRL_SUPPL_BIT] |=>
            $past(state_next) != CCC_DONE || !drive.battery_switch)
        else $error("battery switch on after done");

    a_fault_freezes: assert property (@(posedge pclk) disable iff (!presetn)
        state_reg == CCC_CHARGING && charge_fault && !restart |=> $stable(safety_cnt_reg))
        else $error("safety timer moved during fault");

    a_input_ov_halt: assert property (@(posedge pclk) disable iff (!presetn)
        sense.input_overvoltage |=> !drive.high_side_switch)
        else $error("high side switch active on input overvoltage");

    a_sys_ov_sink: assert property (@(posedge pclk) disable iff (!presetn)
        sense.system_overvoltage |=> drive.system_discharge_sink && !drive.switching_enable)
        else $error("system overvoltage not clamped");

    a_bat_ov_stop: assert property (@(posedge pclk) disable iff (!presetn)
        sense.battery_overvoltage |=> !drive.charge_enable)
        else $error("charging on battery overvoltage");

    a_latch_holds: assert property (@(posedge pclk) disable iff (!presetn)
        latch_off_reg && !sense.input_plugin |=> latch_off_reg ##1 !drive.battery_switch)
        else $error("battery switch latch released without plug-in");

    a_boost_window: assert property (@(posedge pclk) disable iff (!presetn)
        !sense.ts_boost_window |=> !drive.reverse_supply_output)
        else $error("boost ran outside thermistor window");

    a_retry_out: assert property (@(posedge pclk) disable iff (!presetn)
        otg_dead_reg |=> !drive.reverse_supply_output)
        else $error("boost after retries");

    a_short_sel: assert property (@(posedge pclk) disable iff (!presetn)
        sense.vbat_below_short |=> drive.current_sel == CCC_I_SHORT)
        else $error("short current missed");

endmodule

// [bench/ccc_far_side_model.sv]
`timescale 1ns/1ps
// battery, supply and thermistor as comparator flags
module ccc_far_side_model #(
    parameter int LOW_MV = 3000,
    parameter int SHORT_MV = 2200,
    parameter int RECH_MV = 4100
) (
    // scenario knobs
    input wire logic [12:0] vbat_mv,
    input wire logic [2:0] ts_zone,
    input wire ccc_pkg::ccc_sense_t sense_req,
    // flags to the controller
    output ccc_pkg::ccc_sense_t sense
);
    import ccc_pkg::*;
    // zone 0 cold, 1 cool, 2 normal, 3 warm, 4 hot
    // flags only move when the bench moves a knob, so they stay synchronous
    always_comb begin
        sense = sense_req;
        sense.vbat_below_low = int'(vbat_mv) < LOW_MV;
        sense.vbat_below_short = int'(vbat_mv) < SHORT_MV;
        sense.vbat_above_recharge = int'(vbat_mv) > RECH_MV;
        // boost window kept equal to the charge zone for brevity
        sense.ts_in_charge_zone = ts_zone inside {3'd1, 3'd2, 3'd3};
        sense.ts_boost_window = ts_zone inside {3'd1, 3'd2, 3'd3};
        sense.ts_cool = ts_zone == 3'd1;
        sense.ts_warm = ts_zone == 3'd3;
    end
endmodule

// [bench/tb_charge_cycle_controller.sv]
`timescale 1ns/1ps
// self-checking bench for the charge cycle controller
module tb_charge_cycle_controller;
    import ccc_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, slv;
    logic charge_enable_n, status_out, s;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [12:0] vbat_mv;
    logic [2:0] ts_zone;
    ccc_sense_t sreq, sense;
    ccc_drive_t drive;
    int err_total = 0;
    int comparisons = 0;
    int wd = 0;
    // brief counts: 4-cycle tick, 20 and 100 tick timers
    ccc_charge_cycle_controller #(.TICK_CYCLES(4), .SAFETY_SHORT_TICKS(20), .SAFETY_LONG_TICKS(100)) DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .charge_enable_n(charge_enable_n), .sense(sense), .drive(drive), .status_out(status_out));
    ccc_far_side_model far (.vbat_mv(vbat_mv), .ts_zone(ts_zone), .sense_req(sreq), .sense(sense));
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    // hang guard
    always @(posedge pclk) begin
        wd <= wd + 1;
        if (wd == 20000) begin
            err_total++;
            close_out();
        end
    end
    task automatic close_out();
        if (err_total == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
            err_total++;
        end
    endtask
    // one apb transfer, request held until pready is seen
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        slv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // stop and start a cycle through the enable pin
    task automatic restart();
        charge_enable_n <= 1'b1;
        cyc(3);
        charge_enable_n <= 1'b0;
        cyc(4);
    endtask
    // charging must hold until lo cycles and stop by hi
    task automatic expire(input int lo, input int hi);
        int n;
        cyc(lo);
        chk("ce_before_expiry", 32'h1, 32'(drive.charge_enable));
        n = lo;
        while (drive.charge_enable === 1'b1 && n < hi) begin
            cyc(1);
            n++;
        end
        chk("ce_after_expiry", 32'h0, 32'(drive.charge_enable));
    endtask
    task automatic t_regs();
        chk("drive_reset", 32'h0, 32'(drive));
        chk("status_reset", 32'h1, 32'(status_out));
        apb(1'b0, CCC_CTRL_OFS, 32'h0);
        chk("ctrl_reset", 32'(CCC_CTRL_RESET), rd);
        apb(1'b1, CCC_CTRL_OFS, 32'h3);
        apb(1'b0, CCC_CTRL_OFS, 32'h0);
        chk("ctrl_rw", 32'h3, rd);
        apb(1'b1, CCC_CTRL_OFS, 32'h0);
        apb(1'b1, CCC_STATUS_OFS, 32'h7);
        apb(1'b0, CCC_STATUS_OFS, 32'h0);
        chk("status_ro", 32'h0, 32'(rd[2:0]));
        apb(1'b0, 8'h10, 32'h0);
        chk("unmapped_err", 32'h1, 32'(slv));
        chk("unmapped_data", 32'h0, rd);
    endtask
    task automatic t_start();
        sreq.conv_running <= 1'b1;
        ts_zone <= 3'd0;
        charge_enable_n <= 1'b0;
        cyc(4);
        chk("ce_cold", 32'h0, 32'(drive.charge_enable));
        ts_zone <= 3'd2;
        cyc(3);
        chk("ce_start", 32'h1, 32'(drive.charge_enable));
        chk("status_chg", 32'h0, 32'(status_out));
        apb(1'b1, CCC_CTRL_OFS, 32'h1);
        cyc(2);
        chk("ce_inhibit", 32'h0, 32'(drive.charge_enable));
        apb(1'b1, CCC_CTRL_OFS, 32'h0);
    endtask
    task automatic t_sel();
        int mv[5] = '{3800, 3800, 3800, 2600, 2000};
        int zn[5] = '{2, 1, 3, 2, 2};
        ccc_isel_t es[5] = '{CCC_I_FAST, CCC_I_COOL_20PCT, CCC_I_FAST, CCC_I_PRE_5PCT, CCC_I_SHORT};
        logic ev[5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
        restart();
        for (int i = 0; i < 5; i++) begin
            vbat_mv <= 13'(mv[i]);
            ts_zone <= 3'(zn[i]);
            cyc(3);
            chk("current_sel", 32'(es[i]), 32'(drive.current_sel));
            chk("voltage_reduced", 32'(ev[i]), 32'(drive.voltage_reduced));
        end
        vbat_mv <= 13'd3800;
        ts_zone <= 3'd2;
    endtask
    task automatic t_term();
        restart();
        sreq.fast_charge_current_below_term <= 1'b1;
        sreq.thermal_regulation <= 1'b1;
        vbat_mv <= 13'd4200;
        cyc(5);
        chk("ce_thermal", 32'h1, 32'(drive.charge_enable));
        sreq.thermal_regulation <= 1'b0;
        sreq.power_regulation_state <= 1'b1;
        cyc(5);
        chk("ce_powreg", 32'h1, 32'(drive.charge_enable));
        sreq.power_regulation_state <= 1'b0;
        cyc(3);
        chk("ce_done", 32'h0, 32'(drive.charge_enable));
        chk("bsw_done", 32'h0, 32'(drive.battery_switch));
        chk("status_done", 32'h1, 32'(status_out));
        sreq.supplement_demand <= 1'b1;
        cyc(2);
        chk("bsw_demand", 32'h1, 32'(drive.battery_switch));
        sreq.supplement_demand <= 1'b0;
        apb(1'b1, CCC_CTRL_OFS, 32'h2);
        cyc(2);
        chk("bsw_suppl", 32'h1, 32'(drive.battery_switch));
        apb(1'b1, CCC_CTRL_OFS, 32'h0);
        sreq.fast_charge_current_below_term <= 1'b0;
        vbat_mv <= 13'd3900;
        cyc(3);
        chk("ce_recharge", 32'h1, 32'(drive.charge_enable));
        sreq.fast_charge_current_below_term <= 1'b1;
        vbat_mv <= 13'd4200;
        cyc(3);
        sreq.fast_charge_current_below_term <= 1'b0;
        restart();
        chk("ce_toggle", 32'h1, 32'(drive.charge_enable));
        vbat_mv <= 13'd2600;
    endtask
    task automatic t_timer();
        int n;
        restart();
        expire(70, 90);
        cyc(2);
        s = status_out;
        n = 0;
        while (status_out === s && n < 2100) begin
            cyc(1);
            n++;
        end
        chk("status_blink", 32'(!s), 32'(status_out));
        sreq.vin_regulation <= 1'b1;
        restart();
        expire(150, 170);
        sreq.vin_regulation <= 1'b0;
        vbat_mv <= 13'd3800;
        restart();
        expire(390, 410);
        vbat_mv <= 13'd2600;
        restart();
        cyc(40);
        sreq.battery_overvoltage <= 1'b1;
        cyc(3);
        chk("ce_battery_overvoltage", 32'h0, 32'(drive.charge_enable));
        cyc(97);
        sreq.battery_overvoltage <= 1'b0;
        expire(30, 50);
        vbat_mv <= 13'd3800;
    endtask
    task automatic t_prot();
        restart();
        sreq.input_overvoltage <= 1'b1;
        cyc(3);
        chk("hss_input_overvoltage", 32'h0, 32'(drive.high_side_switch));
        sreq.input_overvoltage <= 1'b0;
        cyc(3);
        chk("hss_back", 32'h1, 32'(drive.high_side_switch));
        sreq.system_overvoltage <= 1'b1;
        cyc(3);
        chk("sw_system_overvoltage", 32'h0, 32'(drive.switching_enable));
        chk("sink_system_overvoltage", 32'h1, 32'(drive.system_discharge_sink));
        sreq.system_overvoltage <= 1'b0;
        for (int i = 0; i < 2; i++) begin
            sreq.vbat_below_depletion <= (i == 0);
            sreq.battery_overcurrent <= (i == 1);
            cyc(2);
            sreq.vbat_below_depletion <= 1'b0;
            sreq.battery_overcurrent <= 1'b0;
            cyc(3);
            chk("bsw_latched", 32'h0, 32'(drive.battery_switch));
            sreq.input_plugin <= 1'b1;
            cyc(1);
            sreq.input_plugin <= 1'b0;
            cyc(3);
            chk("bsw_plugin", 32'h1, 32'(drive.battery_switch));
        end
    endtask
    task automatic t_boost();
        sreq.conv_running <= 1'b0;
        sreq.boost_request <= 1'b1;
        cyc(3);
        chk("otg_on", 32'h1, 32'(drive.reverse_supply_output));
        ts_zone <= 3'd4;
        cyc(3);
        chk("otg_hot", 32'h0, 32'(drive.reverse_supply_output));
        ts_zone <= 3'd2;
        sreq.die_above_shutdown <= 1'b1;
        cyc(3);
        chk("otg_tshut", 32'h0, 32'(drive.reverse_supply_output));
        chk("bsw_tshut", 32'h0, 32'(drive.battery_switch));
        sreq.die_above_shutdown <= 1'b0;
        sreq.die_below_restore <= 1'b1;
        cyc(3);
        chk("bsw_restore", 32'h1, 32'(drive.battery_switch));
        for (int i = 1; i <= 8; i++) begin
            sreq.bus_short <= 1'b1;
            cyc(1);
            sreq.bus_short <= 1'b0;
            cyc(3);
            if (i == 7) chk("otg_retry", 32'h1, 32'(drive.reverse_supply_output));
        end
        chk("otg_exhaust", 32'h0, 32'(drive.reverse_supply_output));
        apb(1'b0, CCC_RETRY_OFS, 32'h0);
        chk("retry_count", 32'(CCC_BOOST_RETRIES), 32'(rd[2:0]));
    endtask
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        charge_enable_n = 1'b1;
        sreq = '0;
        vbat_mv = 13'd3800;
        ts_zone = 3'd2;
        cyc(6);
        presetn <= 1'b1;
        t_regs();
        t_start();
        t_sel();
        t_term();
        t_timer();
        t_prot();
        t_boost();
        close_out();
    end
endmodule
